// ===== swf_host.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Host software model driving the register port
module swf_host (
  input  wire logic       clock,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  input  wire logic [7:0] reg_rdata
);
  // Idle bus after time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
  end

  // One-cycle write strobe; data inverted once released so stale data never matches
  // service key writes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask

  // Read is combinational, taken one edge after the address settles
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    @(posedge clock);
    d = reg_rdata;
  endtask
endmodule

`default_nettype wire

// ===== swf_pkg.sv
package swf_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_WAKE_CFG = 8'h12;
  localparam logic [7:0] ADDR_WD_MODE  = 8'h13;
  localparam logic [7:0] ADDR_WD_TIME  = 8'h14;
  localparam logic [7:0] ADDR_WD_SVC   = 8'h15;
  localparam logic [7:0] ADDR_WD_THR   = 8'h16;
  localparam logic [7:0] ADDR_FS_ACT   = 8'h17;
  localparam logic [7:0] ADDR_FS_CNT   = 8'h18;

  // ==========================================================
  // Field layouts, most significant field first
  typedef struct packed {
    logic       pulse_dir;    // Bit 7
    logic       sense_cyclic; // Bit 6
    logic       sample_long;  // Bit 5
    logic [1:0] irq_fn;       // Bits 4-3
    logic       rx_toggle;    // Bit 2
    logic [1:0] threshold;    // Bits 1-0
  } swf_wake_t;

  typedef struct packed {
    logic [1:0] mode;         // Bits 7-6
    logic [1:0] prescaler;    // Bits 5-4
    logic [3:0] rsvd;         // Bits 3-0
  } swf_wdmode_t;

  typedef struct packed {
    logic [2:0] period_sel;   // Bits 7-5
    logic [3:0] err_count;    // Bits 4-1
    logic       stby_dis;     // Bit 0
  } swf_wdtime_t;

  typedef struct packed {
    logic [1:0] err_thr;      // Bits 7-6
    logic [5:0] rsvd;         // Bits 5-0
  } swf_wdthr_t;

  typedef struct packed {
    logic [3:0] action;       // Bits 7-4
    logic [2:0] reason;       // Bits 3-1
    logic       disable_fs;   // Bit 0
  } swf_fsact_t;

  typedef struct packed {
    logic [3:0] restart_thr;  // Bits 7-4
    logic [3:0] entry_count;  // Bits 3-0
  } swf_fscnt_t;

  // ==========================================================
  // Reset values
  localparam swf_wake_t   RST_WAKE   = 8'h02;
  localparam swf_wdmode_t RST_WDMODE = 8'h90;
  localparam swf_wdtime_t RST_WDTIME = 8'h02;
  localparam swf_wdthr_t  RST_WDTHR  = 8'h40;
  localparam swf_fsact_t  RST_FSACT  = 8'h00;
  localparam swf_fscnt_t  RST_FSCNT  = 8'h00;

  // ==========================================================
  // Codes
  localparam logic [1:0] IRQ_GLOBAL  = 2'h0;
  localparam logic [1:0] IRQ_WDFAIL  = 2'h1;
  localparam logic [1:0] IRQ_RSVD    = 2'h2;
  localparam logic [1:0] IRQ_WAKE    = 2'h3;
  localparam logic [1:0] WD_OFF      = 2'h0;
  localparam logic [1:0] WD_TIMEOUT  = 2'h1;
  localparam logic [1:0] WD_WINDOW   = 2'h2;
  localparam logic [1:0] WD_RSVD     = 2'h3;
  localparam logic [3:0] ACT_NONE    = 4'h0;
  localparam logic [3:0] ACT_INH_LOW = 4'h1;
  localparam logic [3:0] ACT_SOFT    = 4'h2;
  localparam logic [3:0] ACT_POR     = 4'h3;
  localparam logic [3:0] ACT_SLEEP   = 4'h4;
  localparam logic [3:0] ACT_VCC_OFF = 4'h9;
  localparam logic [2:0] FS_WDFAIL   = 3'h6;
  localparam logic [2:0] FS_RESTART  = 3'h7;
  localparam logic [7:0] WD_SVC_KEY  = 8'hff;
  localparam logic [3:0] ERR_MAX     = 4'hf;
  localparam logic [3:0] ERR_START   = 4'h1;
  localparam logic [3:0] ERR_THR_A   = 4'h5;
  localparam logic [3:0] ERR_THR_B   = 4'h9;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS   = 20;
  localparam int SAMPLE_SHORT_US = 30;
  localparam int SAMPLE_LONG_US  = 75;
  localparam int SAMPLE_SHORT_CYC = SAMPLE_SHORT_US * 1000 / CLK_PERIOD_NS;
  localparam int SAMPLE_LONG_CYC  = SAMPLE_LONG_US * 1000 / CLK_PERIOD_NS;
  localparam int TICK_MS         = 1;
  localparam int TICK_CYC        = TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int INH_LOW_MS      = 1000;
  localparam int VCC_OFF_MS      = 300;
  localparam int WD_UNIT_MS      = 10;

endpackage

// ===== swf_regs.sv
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Pulse direction bit: 0 low-high-low, 1 high-low-high; resets 0.
// - Sense bit: 0 static, 1 cyclic; hardware may update; resets static.
// - Sample time bit picks 30 us or 75 us cyclic sampling.
// - Interrupt output source: 00 global, 01 watchdog fail, 11 wake; 10 reserved.
// - Receive pin after wake: 0 held low, 1 toggles.
// - Wake threshold 2.5/2.8/3/3.3 V by code; resets to 10.
// - Watchdog mode: 00 off, 01 timeout, 10 window (reset); 11 reserved.
// - Prescaler factor 1 to 4 by code; resets to factor 2.
// - Period select bits 7-5 set duration with prescaler; resets 000.
// - Read-only error count bits 4-1, saturates at 15, resets to 1.
// - Standby disable bit 1 turns watchdog off in standby.
// - Writing FFh to service register restarts watchdog if timely; reads 00h.
// - Error threshold: every fail, 5, 9 or 15 errors; resets 01.
// - Restart overflow action: none, inhibit low 1 s, soft reset, POR, sleep.
// - Action 1001 cuts supply 300 ms and raises interrupt; 0101-0111 reserved.
// - Fail-safe reason code reports cause; 010 reserved.
// - Reason stays latched until zero written to entry count.
// - Fail-safe disable blocks entries except power-up fail-safe.
// - Consecutive entries counted to 15; writing zero clears count.
// - Restart threshold holds entries minus one, 1 to 16 entries.
// - Soft reset restores register defaults, inhibit output keeps its current level.
module swf_regs
  import swf_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int UNIT_MS     = WD_UNIT_MS
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  output logic      [7:0] reg_rdata,
  input  wire logic       soft_reset_request,
  input  wire logic       standby_mode,
  input  wire logic       wake_sense_hw_wr,
  input  wire logic       wake_sense_hw_val,
  input  wire logic       global_irq,
  input  wire logic       wake_request,
  input  wire logic       fs_event,
  input  wire logic [2:0] fs_cause,
  input  wire logic       fs_powerup,
  output swf_wake_t       wake_cfg,
  output logic     [11:0] wake_sample_cycles,
  output logic            irq_output_n,
  output logic            watchdog_fail,
  output logic            inhibit_output,
  output logic            supply_off,
  output logic            por_request,
  output logic            sleep_lock
);

  // ==========================================================
  // State and ticks
  typedef enum logic [1:0] {
    SWF_IDLE,
    SWF_INH_LOW,
    SWF_VCC_OFF
  } swf_act_state_t;

  swf_wake_t      wake,      next_wake;
  swf_wdmode_t    wdm,       next_wdm;
  swf_wdtime_t    wdt,       next_wdt;
  swf_wdthr_t     wthr,      next_wthr;
  swf_fsact_t     fsa,       next_fsa;
  swf_fscnt_t     fsc,       next_fsc;
  logic    [11:0] wd_cnt,    next_wd_cnt;
  logic           wd_fail_l, next_wd_fail_l;
  logic           sup_irq,   next_sup_irq;
  logic           por_q,     next_por_q;
  logic           sleep_q,   next_sleep_q;
  logic    [9:0]  act_cnt,   next_act_cnt;
  swf_act_state_t act_st,    next_act_st;
  logic           ms_tick;

  swf_tick_div #(
    .DIV (TICK_CYCLES)
  ) u_ms_tick (
    .clock (clock),
    .rst   (rst),
    .tick  (ms_tick)
  );

  // Threshold count for the error counter
  function automatic logic [3:0] err_limit(input logic [1:0] code);
    unique case (code)
      2'h0:    err_limit = ERR_START;
      2'h1:    err_limit = ERR_THR_A;
      2'h2:    err_limit = ERR_THR_B;
      2'h3:    err_limit = ERR_MAX;
    endcase
  endfunction

  // Only documented action codes are accepted
  function automatic logic action_valid(input logic [3:0] code);
    action_valid = (code <= ACT_SLEEP) || (code == ACT_VCC_OFF);
  endfunction

  // ==========================================================
  // Watchdog timing terms
  logic        svc_wr;
  logic        wd_on;
  logic [11:0] wd_period;
  logic        wd_timeout;
  logic        wd_early;
  logic        wd_err;
  logic        wd_action;
  logic        fs_take;
  logic        fs_overflow;
  logic        cnt_clear;

  assign svc_wr = reg_wr && (reg_addr == ADDR_WD_SVC) && (reg_wdata == WD_SVC_KEY);
  assign wd_on = (wdm.mode == WD_TIMEOUT || wdm.mode == WD_WINDOW) &&
                 !(standby_mode && wdt.stby_dis);
  // Period from select and prescaler, in units of UNIT_MS
  assign wd_period = 12'((32'(wdt.period_sel) + 32'd1) * (32'(wdm.prescaler) + 32'd1)
                         * 32'(UNIT_MS));
  assign wd_timeout = wd_on && ms_tick && (wd_cnt + 12'h001 >= wd_period);
  // Service in the closed half of a window counts as an error
  assign wd_early = wd_on && svc_wr && (wdm.mode == WD_WINDOW) &&
                    (wd_cnt < (wd_period >> 1));
  assign wd_err = wd_timeout || wd_early;
  // Action when count reaches the selected threshold
  assign wd_action = wd_err && ((wthr.err_thr == 2'h0) ||
                     (wdt.err_count + 4'h1 >= err_limit(wthr.err_thr)));
  // Disable blocks all entries except at power-up
  assign fs_take = (fs_event && (!fsa.disable_fs || fs_powerup)) ||
                   (wd_action && !fsa.disable_fs);
  // Overflow after threshold plus one entries
  assign fs_overflow = fs_take && (fsc.entry_count >= fsc.restart_thr);
  assign cnt_clear = reg_wr && (reg_addr == ADDR_FS_CNT) && (reg_wdata[3:0] == 4'h0);

  // ==========================================================
  // Next values of registers and action sequencer
  always_comb begin
    next_wake      = wake;
    next_wdm       = wdm;
    next_wdt       = wdt;
    next_wthr      = wthr;
    next_fsa       = fsa;
    next_fsc       = fsc;
    next_wd_cnt    = wd_cnt;
    next_wd_fail_l = wd_fail_l;
    next_sup_irq   = sup_irq;
    next_por_q     = 1'b0;
    next_sleep_q   = sleep_q;
    next_act_cnt   = act_cnt;
    next_act_st    = act_st;

    // Host writes; reserved bits never stored
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_WAKE_CFG: begin
          next_wake.pulse_dir    = reg_wdata[7];
          next_wake.sense_cyclic = reg_wdata[6];
          next_wake.sample_long  = reg_wdata[5];
          next_wake.rx_toggle    = reg_wdata[2];
          next_wake.threshold    = reg_wdata[1:0];
          // Reserved source code keeps old one
          if (reg_wdata[4:3] != IRQ_RSVD) begin
            next_wake.irq_fn = reg_wdata[4:3];
          end
        end
        ADDR_WD_MODE: begin
          if (reg_wdata[7:6] != WD_RSVD) begin
            next_wdm.mode = reg_wdata[7:6];
          end
          next_wdm.prescaler = reg_wdata[5:4];
        end
        ADDR_WD_TIME: begin
          next_wdt.period_sel = reg_wdata[7:5];
          next_wdt.stby_dis   = reg_wdata[0];
        end
        ADDR_WD_THR: begin
          next_wthr.err_thr = reg_wdata[7:6];
        end
        ADDR_FS_ACT: begin
          if (action_valid(reg_wdata[7:4])) begin
            next_fsa.action = reg_wdata[7:4];
          end
          next_fsa.disable_fs = reg_wdata[0];
        end
        ADDR_FS_CNT: begin
          next_fsc.restart_thr = reg_wdata[7:4];
          // Zero write clears count and reason
          if (cnt_clear) begin
            next_fsc.entry_count = 4'h0;
            next_fsa.reason      = 3'h0;
            next_sup_irq         = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    if (wake_sense_hw_wr) begin
      next_wake.sense_cyclic = wake_sense_hw_val;
    end

    // Restart on valid service, error restarts too
    if (!wd_on) begin
      next_wd_cnt = 12'h000;
    end else if (wd_err || svc_wr) begin
      next_wd_cnt    = 12'h000;
      next_wd_fail_l = wd_err ? wd_fail_l : 1'b0;
    end else if (ms_tick) begin
      next_wd_cnt = wd_cnt + 12'h001;
    end

    // Error count saturating at 15, restarts after action
    if (wd_action) begin
      next_wdt.err_count = ERR_START;
      next_wd_fail_l     = 1'b1;
    end else if (wd_err && wdt.err_count != ERR_MAX) begin
      next_wdt.err_count = wdt.err_count + 4'h1;
    end

    // Entry latches reason; set wins over clear
    if (fs_take) begin
      if (fsc.entry_count != ERR_MAX) begin
        next_fsc.entry_count = fsc.entry_count + 4'h1;
      end
      next_fsa.reason = fs_event ? fs_cause : FS_WDFAIL;
    end

    // Timed actions in ms ticks; a new inhibit-low or supply-off action below restarts the count
    unique case (act_st)
      SWF_IDLE: begin
      end
      SWF_INH_LOW: begin
        if (ms_tick) begin
          next_act_cnt = act_cnt + 10'h001;
          if (act_cnt + 10'h001 >= 10'(INH_LOW_MS)) begin
            next_act_st = SWF_IDLE;
          end
        end
      end
      SWF_VCC_OFF: begin
        if (ms_tick) begin
          next_act_cnt = act_cnt + 10'h001;
          if (act_cnt + 10'h001 >= 10'(VCC_OFF_MS)) begin
            next_act_st = SWF_IDLE;
          end
        end
      end
    endcase

    if (fs_overflow) begin
      next_fsa.reason = FS_RESTART;
      unique case (fsa.action)
        ACT_INH_LOW: begin
          next_act_st  = SWF_INH_LOW;
          next_act_cnt = 10'h000;
        end
        ACT_POR:     next_por_q = 1'b1;
        ACT_SLEEP:   next_sleep_q = 1'b1;
        ACT_VCC_OFF: begin
          next_act_st  = SWF_VCC_OFF;
          next_act_cnt = 10'h000;
          next_sup_irq = 1'b1;
        end
        default: begin
        end
      endcase
    end

    // Soft reset restores defaults, pin timers untouched
    if (soft_reset_request || (fs_overflow && fsa.action == ACT_SOFT)) begin
      next_wake      = RST_WAKE;
      next_wdm       = RST_WDMODE;
      next_wdt       = RST_WDTIME;
      next_wthr      = RST_WDTHR;
      next_fsa       = RST_FSACT;
      next_fsc       = RST_FSCNT;
      next_wd_cnt    = 12'h000;
      next_wd_fail_l = 1'b0;
      next_sup_irq   = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wake      <= RST_WAKE;
      wdm       <= RST_WDMODE;
      wdt       <= RST_WDTIME;
      wthr      <= RST_WDTHR;
      fsa       <= RST_FSACT;
      fsc       <= RST_FSCNT;
      wd_cnt    <= 12'h000;
      wd_fail_l <= 1'b0;
      sup_irq   <= 1'b0;
      por_q     <= 1'b0;
      sleep_q   <= 1'b0;
      act_cnt   <= 10'h000;
      act_st    <= SWF_IDLE;
    end else begin
      wake      <= next_wake;
      wdm       <= next_wdm;
      wdt       <= next_wdt;
      wthr      <= next_wthr;
      fsa       <= next_fsa;
      fsc       <= next_fsc;
      wd_cnt    <= next_wd_cnt;
      wd_fail_l <= next_wd_fail_l;
      sup_irq   <= next_sup_irq;
      por_q     <= next_por_q;
      sleep_q   <= next_sleep_q;
      act_cnt   <= next_act_cnt;
      act_st    <= next_act_st;
    end
  end

  // ==========================================================
  // Read data and outputs
  // Reserved fields are zero; service register reads zero
  always_comb begin
    unique case (reg_addr)
      ADDR_WAKE_CFG: reg_rdata = wake;
      ADDR_WD_MODE:  reg_rdata = {wdm.mode, wdm.prescaler, 4'h0};
      ADDR_WD_TIME:  reg_rdata = wdt;
      ADDR_WD_THR:   reg_rdata = {wthr.err_thr, 6'h00};
      ADDR_FS_ACT:   reg_rdata = fsa;
      ADDR_FS_CNT:   reg_rdata = fsc;
      default:       reg_rdata = 8'h00;
    endcase
  end

  assign wake_cfg = wake;
  assign wake_sample_cycles = wake.sample_long ? 12'(SAMPLE_LONG_CYC)
                                               : 12'(SAMPLE_SHORT_CYC);

  always_comb begin
    unique case (wake.irq_fn)
      IRQ_WDFAIL: irq_output_n = !wd_fail_l;
      IRQ_WAKE:   irq_output_n = !wake_request;
      default:    irq_output_n = !(global_irq || sup_irq);
    endcase
  end

  assign watchdog_fail  = wd_fail_l;
  // Inhibit held unless the 1 s low action runs
  assign inhibit_output = (act_st != SWF_INH_LOW);
  assign supply_off     = (act_st == SWF_VCC_OFF);
  assign por_request    = por_q;
  assign sleep_lock     = sleep_q;
endmodule

`default_nettype wire

// ===== swf_regs_bench.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Bench top
module swf_regs_bench
  import swf_pkg::*;
;
  logic clock = 1'b0, rst = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, soft_reset_request = 0, wake_sense_hw_wr = 0, wake_sense_hw_val = 0;
  logic global_irq = 0, wake_request = 0, fs_event = 0, fs_powerup = 0, standby_mode = 0;
  logic [2:0] fs_cause = 3'h0;
  logic irq_output_n, watchdog_fail, inhibit_output, supply_off, por_request, sleep_lock;
  logic [11:0] wake_sample_cycles;
  logic [4:0] outs;
  swf_wake_t wake_cfg;
  int bad_count = 0, total_checks = 0, cycles = 0;
  logic [7:0] wa [7] = '{8'h12, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17};
  logic [7:0] wd [7] = '{8'hff, 8'h10, 8'hff, 8'hff, 8'hff, 8'hff, 8'h51};
  logic [7:0] we [7] = '{8'hff, 8'h18, 8'h30, 8'he3, 8'h00, 8'hc0, 8'h01};
  logic [1:0] fn [3] = '{2'h0, 2'h1, 2'h3};
  logic [3:0] act [4] = '{4'h3, 4'h9, 4'h1, 4'h4};

  always #10 clock = ~clock;
  // Outputs gathered so one wait task serves all of them
  assign outs = {sleep_lock, ~inhibit_output, supply_off, por_request, watchdog_fail};

  // Short ticks so watchdog and action timers finish quickly
  swf_regs #(.TICK_CYCLES(10), .UNIT_MS(1)) u_dut (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rdata(reg_rdata), .soft_reset_request(soft_reset_request), .standby_mode(standby_mode),
    .wake_sense_hw_wr(wake_sense_hw_wr), .wake_sense_hw_val(wake_sense_hw_val),
    .global_irq(global_irq), .wake_request(wake_request), .fs_event(fs_event),
    .fs_cause(fs_cause), .fs_powerup(fs_powerup), .wake_cfg(wake_cfg),
    .wake_sample_cycles(wake_sample_cycles), .irq_output_n(irq_output_n),
    .watchdog_fail(watchdog_fail), .inhibit_output(inhibit_output), .supply_off(supply_off),
    .por_request(por_request), .sleep_lock(sleep_lock)
  );
  swf_host u_host (
    .clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rdata(reg_rdata)
  );

  // ==========================================================
  // Checking helpers
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    u_host.rd(a, v);
    chk($sformatf("register %h", a), {8'h00, e}, {8'h00, v});
  endtask
  // Bounded wait on one output, then compare
  task automatic wait_out(input int i, input logic v, input string what);
    int n;
    n = 0;
    while (outs[i] !== v && n < 200) begin
      @(posedge clock);
      n++;
    end
    chk(what, {15'h0, v}, {15'h0, outs[i]});
  endtask
  task automatic fs(input logic [2:0] c, input logic pu);
    @(posedge clock);
    fs_event   <= 1'b1;
    fs_cause   <= c;
    fs_powerup <= pu;
    @(posedge clock);
    fs_event   <= 1'b0;
  endtask

  // Hang guard well above the expected run length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      results();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    rc(8'h14, 8'h02);
    rc(8'h13, 8'h90);
    u_host.wr(8'h13, 8'h10);
    rc(8'h12, 8'h02);
    rc(8'h16, 8'h40);
    rc(8'h17, 8'h00);
    rc(8'h18, 8'h00);
    rc(8'h15, 8'h00);
    rc(8'h11, 8'h00);
    // Reserved bits, reserved codes and read-only fields
    for (int i = 0; i < 7; i++) begin
      u_host.wr(wa[i], wd[i]);
      rc(wa[i], we[i]);
    end
    chk("sample cycles", 16'd1500, {4'h0, wake_sample_cycles});
    // Interrupt output source per function code
    // No timer on-width here, so 75 us sampling is legal
    global_irq <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      u_host.wr(8'h12, {3'b001, fn[i], 3'b000});
      @(posedge clock);
      chk("irq output", {15'h0, i != 0}, {15'h0, irq_output_n});
    end
    wake_request <= 1'b1;
    @(posedge clock);
    chk("wake irq output", 16'h0000, {15'h0, irq_output_n});
    wake_request <= 1'b0;
    chk("sample cycles", 16'd3750, {4'h0, wake_sample_cycles});
    @(posedge clock);
    wake_sense_hw_wr  <= 1'b1;
    wake_sense_hw_val <= 1'b1;
    @(posedge clock);
    wake_sense_hw_wr  <= 1'b0;
    rc(8'h12, 8'h78);
    // Watchdog held off in standby, then failure on every error
    u_host.wr(8'h18, 8'hf0);
    u_host.wr(8'h17, 8'h00);
    u_host.wr(8'h16, 8'h00);
    u_host.wr(8'h14, 8'h01);
    standby_mode <= 1'b1;
    u_host.wr(8'h13, 8'h40);
    repeat (30) @(posedge clock);
    chk("standby watchdog", 16'h0000, {15'h0, watchdog_fail});
    standby_mode <= 1'b0;
    wait_out(0, 1'b1, "watchdog fail");
    // Longer timeout keeps the watchdog from timing out before the service, so the service counts
    u_host.wr(8'h13, 8'h70);
    rc(8'h17, 8'h0c);
    rc(8'h18, 8'hf1);
    u_host.wr(8'h15, 8'hff);
    wait_out(0, 1'b0, "watchdog fail cleared");
    // Service in the closed half of a window is an error
    u_host.wr(8'h13, 8'hb0);
    u_host.wr(8'h15, 8'hff);
    wait_out(0, 1'b1, "early service");
    u_host.wr(8'h13, 8'h00);
    u_host.wr(8'h18, 8'hf0);
    rc(8'h17, 8'h00);
    // Disable blocks entries except power-up
    u_host.wr(8'h17, 8'h01);
    fs(3'h3, 1'b0);
    rc(8'h18, 8'hf0);
    fs(3'h3, 1'b1);
    rc(8'h18, 8'hf1);
    rc(8'h17, 8'h07);
    // Overflow actions with restart threshold of one entry
    u_host.wr(8'h18, 8'h00);
    for (int i = 0; i < 4; i++) begin
      u_host.wr(8'h17, {act[i], 4'h0});
      fs(3'h1, 1'b0);
      wait_out(i + 1, 1'b1, $sformatf("action %h", act[i]));
      if (i == 0)
        rc(8'h17, 8'h3e);
    end
    // Soft reset keeps the inhibit output low
    @(posedge clock);
    soft_reset_request <= 1'b1;
    @(posedge clock);
    soft_reset_request <= 1'b0;
    rc(8'h13, 8'h90);
    chk("inhibit held", 16'h0000, {15'h0, inhibit_output});
    u_host.wr(8'h13, 8'h10);
    u_host.wr(8'h17, 8'h20);
    fs(3'h1, 1'b0);
    repeat (3) @(posedge clock);
    rc(8'h13, 8'h90);
    results();
  end
endmodule

`default_nettype wire

// ===== swf_regs_sva.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Port-level checker
module swf_regs_sva
  import swf_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       soft_reset_request,
  input  wire logic       wake_sense_hw_wr,
  input  wire logic       wake_sense_hw_val,
  input  wire logic       wake_request,
  input  wire swf_wake_t  wake_cfg,
  input  wire logic[11:0] wake_sample_cycles,
  input  wire logic       irq_output_n,
  input  wire logic       watchdog_fail,
  input  wire logic       por_request,
  input  wire logic       sleep_lock
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // Plain wake writes, minus hardware or soft-reset collisions
  logic wake_wr;
  assign wake_wr = reg_wr && reg_addr == ADDR_WAKE_CFG && !wake_sense_hw_wr
                   && !soft_reset_request;

  property p_unmapped_zero;
    (reg_addr < ADDR_WAKE_CFG || reg_addr > ADDR_FS_CNT) |-> reg_rdata == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
  property p_svc_zero;
    reg_addr == ADDR_WD_SVC |-> reg_rdata == 8'h00;
  endproperty
  a_svc_zero: assert property (p_svc_zero) else $error("service register not zero");
  property p_wake_store;
    wake_wr && reg_wdata[4:3] != IRQ_RSVD |=> wake_cfg == $past(reg_wdata);
  endproperty
  a_wake_store: assert property (p_wake_store) else $error("wake write not stored");
  property p_irq_rsvd;
    wake_wr && reg_wdata[4:3] == IRQ_RSVD |=> $stable(wake_cfg.irq_fn);
  endproperty
  a_irq_rsvd: assert property (p_irq_rsvd) else $error("reserved irq code stored");
  property p_sample;
    wake_sample_cycles == (wake_cfg.sample_long ? 12'd3750 : 12'd1500);
  endproperty
  a_sample: assert property (p_sample) else $error("sample cycles wrong");
  property p_irq_wake;
    wake_cfg.irq_fn == IRQ_WAKE |-> irq_output_n == !wake_request;
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("wake irq source wrong");
  property p_irq_wd;
    wake_cfg.irq_fn == IRQ_WDFAIL |-> irq_output_n == !watchdog_fail;
  endproperty
  a_irq_wd: assert property (p_irq_wd) else $error("watchdog irq source wrong");
  property p_hw_sense;
    wake_sense_hw_wr && !soft_reset_request && !(reg_wr && reg_addr == ADDR_WAKE_CFG)
      |=> wake_cfg.sense_cyclic == $past(wake_sense_hw_val);
  endproperty
  a_hw_sense: assert property (p_hw_sense) else $error("hardware sense update lost");
  property p_soft;
    soft_reset_request && !reg_wr |=> wake_cfg == RST_WAKE;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset left wake config");
  property p_por_pulse;
    por_request |=> !por_request;
  endproperty
  a_por_pulse: assert property (p_por_pulse) else $error("reset request too long");
  property p_sleep_hold;
    sleep_lock |=> sleep_lock [*2];
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("sleep lock released");

  // Main scenarios reached
  c_por: cover property (por_request);
  c_wdfail: cover property ($rose(watchdog_fail));
  c_sleep: cover property ($rose(sleep_lock));
endmodule

bind swf_regs swf_regs_sva u_sva (
  .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rdata(reg_rdata), .soft_reset_request(soft_reset_request),
  .wake_sense_hw_wr(wake_sense_hw_wr), .wake_sense_hw_val(wake_sense_hw_val),
  .wake_request(wake_request), .wake_cfg(wake_cfg), .wake_sample_cycles(wake_sample_cycles),
  .irq_output_n(irq_output_n), .watchdog_fail(watchdog_fail), .por_request(por_request),
  .sleep_lock(sleep_lock)
);

`default_nettype wire

// ===== swf_tick_div.sv
`timescale 1ns/1ns
`default_nettype none

// ============================================================
// Divider giving a one-cycle enable every DIV cycles
module swf_tick_div #(
  parameter int DIV = 50000
) (
  input  wire logic clock,
  input  wire logic rst,
  output logic      tick
);
  localparam int W = $clog2(DIV + 1);
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] count;
  logic [W-1:0] next_count;

  // Wrap at the last count and pulse there
  always_comb begin
    next_count = (count == LAST) ? '0 : count + W'(1);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign tick = (count == LAST);
endmodule

`default_nettype wire
